// ### core/eii_top.v
/*
 * External interrupt input front end with AXI4-Lite registers,
 * edge detection, noise filters, latches and fetch address checks.
 * Assumes pins are asynchronous and CPU/fetch signals share clk.
 */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "eii_map.vh"
module eii_top
(
   input  wire        clk,
   input  wire        rst_b,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   input  wire [31:0] s_axi_araddr,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   input  wire        ext_irq_a,
   input  wire        ext_irq_b,
   input  wire        ext_irq_d,
   input  wire        ext_irq_e,
   input  wire        remote_rx_input,
   input  wire [1:0]  remote_edge_sel,
   input  wire        instr_last,
   input  wire [4:0]  irq_ack,
   input  wire        fetch_valid,
   input  wire [19:0] fetch_addr,
   output reg  [4:0]  irq_pending_r,
   output reg         port5_bit0_in_r,
   output reg         timer1_input_r,
   output reg         fetch_nonexist_r,
   output reg  [7:0]  fetch_opcode_r,
   output reg         trap_reset_r
);
   reg         rst_m_r;
   reg         rst_sync_b;
   reg  [3:0]  pin_m_r;
   reg  [3:0]  pin_s_r;
   wire        filt_a;
   wire        filt_b;
   wire        filt_d;
   wire        filt_e;
   wire [4:0]  lvl;
   reg  [4:0]  lvl_prev_r;
   reg  [7:0]  ctrl_r;
   reg  [7:0]  ctrl_prev_r;
   reg  [1:0]  rc_sel_prev_r;
   reg  [4:0]  latch_r;
   reg  [4:0]  latch_nxt;
   reg  [15:0] enable_r;
   reg  [4:0]  edge_hit;
   wire [4:0]  rise;
   wire [4:0]  fall;
   wire [4:0]  ind_en;
   wire [4:0]  gate_en;
   wire        wr_go;
   wire [7:0]  wr_idx;
   wire [7:0]  rd_idx;
   wire        wr_map;
   wire        rd_map;
   wire        in_ram;
   wire        in_regs;
   wire        in_dbuf;
   wire        in_rom;

   // Reset release through two flip-flops
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_m_r    <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_m_r    <= 1'b1;
         rst_sync_b <= rst_m_r;
      end
   end

   // Two-stage pin synchronisers, order a b d e
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         pin_m_r <= 4'hf;
         pin_s_r <= 4'hf;
      end
      else
      begin
         pin_m_r <= {ext_irq_e, ext_irq_d, ext_irq_b, ext_irq_a};
         pin_s_r <= pin_m_r;
      end
   end

   eii_filter #(.COUNT(`EII_AE_REJECT_CYC)) u_filt_a
   (
      .clk        (clk),
      .rst_sync_b (rst_sync_b),
      .level_in   (pin_s_r[0]),
      .level_r    (filt_a)
   );

   eii_filter #(.COUNT(`EII_BD_REJECT_CYC)) u_filt_b
   (
      .clk        (clk),
      .rst_sync_b (rst_sync_b),
      .level_in   (pin_s_r[1]),
      .level_r    (filt_b)
   );

   eii_filter #(.COUNT(`EII_BD_REJECT_CYC)) u_filt_d
   (
      .clk        (clk),
      .rst_sync_b (rst_sync_b),
      .level_in   (pin_s_r[2]),
      .level_r    (filt_d)
   );

   eii_filter #(.COUNT(`EII_AE_REJECT_CYC)) u_filt_e
   (
      .clk        (clk),
      .rst_sync_b (rst_sync_b),
      .level_in   (pin_s_r[3]),
      .level_r    (filt_e)
   );

   // input c arrives filtered from remote block
   assign lvl  = {filt_e, filt_d, remote_rx_input, filt_b, filt_a};
   assign rise = lvl & ~lvl_prev_r;
   assign fall = ~lvl & lvl_prev_r;

   always @*
   begin
      edge_hit[0] = fall[0];
      edge_hit[1] = ctrl_r[`EII_CTRL_BES] ? fall[1] : rise[1];
      edge_hit[2] = (remote_edge_sel[0] & rise[2]) | (remote_edge_sel[1] & fall[2]);
      edge_hit[3] = ctrl_r[`EII_CTRL_DES] ? fall[3] : rise[3];
      edge_hit[4] = fall[4];
      if (ctrl_r[`EII_CTRL_BES] != ctrl_prev_r[`EII_CTRL_BES])
         edge_hit[1] = 1'b0;
      if (ctrl_r[`EII_CTRL_DES] != ctrl_prev_r[`EII_CTRL_DES])
         edge_hit[3] = 1'b0;
      if (remote_edge_sel != rc_sel_prev_r)
         edge_hit[2] = 1'b0;
      // port mode blocks pin a latch
      if (!ctrl_r[`EII_CTRL_PINSEL])
         edge_hit[0] = 1'b0;
   end

   // Register bus decode
   assign wr_go  = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_idx = s_axi_awaddr[9:2];
   assign rd_idx = s_axi_araddr[9:2];
   assign wr_map = (s_axi_awaddr[31:10] == 22'h000000) &&
                   ((wr_idx == `EII_IDX_CTRL) || (wr_idx == `EII_IDX_LATCH) ||
                    (wr_idx == `EII_IDX_ENABLE));
   assign rd_map = (s_axi_araddr[31:10] == 22'h000000) &&
                   ((rd_idx == `EII_IDX_CTRL) || (rd_idx == `EII_IDX_LATCH) ||
                    (rd_idx == `EII_IDX_ENABLE) || (rd_idx == `EII_IDX_STATUS));

   // latch held until ack, load or reset
   always @*
   begin
      latch_nxt = latch_r & ~irq_ack;
      if (wr_go && wr_map && (wr_idx == `EII_IDX_LATCH) && s_axi_wstrb[0])
         latch_nxt = s_axi_wdata[4:0];
      // Edge set wins over clear
      latch_nxt = latch_nxt | edge_hit;
   end

   // Write side and control state
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         // pin a starts as port input
         ctrl_r        <= `EII_CTRL_RESET;
         ctrl_prev_r   <= `EII_CTRL_RESET;
         rc_sel_prev_r <= 2'b00;
         enable_r      <= 16'h0000;
         latch_r       <= 5'h00;
         lvl_prev_r    <= 5'h1f;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `EII_RESP_OK;
      end
      else
      begin
         ctrl_prev_r   <= ctrl_r;
         rc_sel_prev_r <= remote_edge_sel;
         lvl_prev_r    <= lvl;
         latch_r       <= latch_nxt;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `EII_RESP_OK : `EII_RESP_ERR;
            if (wr_map && (wr_idx == `EII_IDX_CTRL) && s_axi_wstrb[0])
               ctrl_r <= s_axi_wdata[7:0] & `EII_CTRL_WMASK;
            if (wr_map && (wr_idx == `EII_IDX_ENABLE))
            begin
               if (s_axi_wstrb[0])
                  enable_r[7:0] <= s_axi_wdata[7:0];
               if (s_axi_wstrb[1])
                  enable_r[15:8] <= s_axi_wdata[15:8];
            end
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read side; control register is write-only
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `EII_RESP_OK;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= rd_map ? `EII_RESP_OK : `EII_RESP_ERR;
         if (rd_idx == `EII_IDX_LATCH)
            s_axi_rdata <= {27'h0000000, latch_r};
         else if (rd_idx == `EII_IDX_ENABLE)
            s_axi_rdata <= {16'h0000, enable_r};
         else if (rd_idx == `EII_IDX_STATUS)
            s_axi_rdata <= {27'h0000000, lvl};
         else
            s_axi_rdata <= 32'h00000000;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   assign ind_en  = {enable_r[`EII_EN_E], enable_r[`EII_EN_D], enable_r[`EII_EN_C],
                     enable_r[`EII_EN_B], enable_r[`EII_EN_A]};
   assign gate_en = ind_en & {4'hf, ctrl_r[`EII_CTRL_PINSEL]} &
                    {5{enable_r[`EII_EN_MASTER]}};

   // sample requests in last instruction cycle
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         irq_pending_r <= 5'h00;
      else if (instr_last)
         irq_pending_r <= latch_nxt & gate_en;
      else
         irq_pending_r <= irq_pending_r & ~irq_ack;
   end

   // filtered pin b to timer, pin a to port
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         timer1_input_r  <= 1'b1;
         port5_bit0_in_r <= 1'b1;
      end
      else
      begin
         timer1_input_r  <= filt_b;
         // port value only in port mode
         port5_bit0_in_r <= ctrl_r[`EII_CTRL_PINSEL] ? 1'b1 : pin_s_r[0];
      end
   end

   // Fetch address classification
   assign in_ram = (fetch_addr >= `EII_RAM_LO) && (fetch_addr <= `EII_RAM_HI);
   assign in_regs = (fetch_addr <= `EII_REGS_HI);
   assign in_dbuf = (fetch_addr >= `EII_DBUF_LO) && (fetch_addr <= `EII_DBUF_HI);
   assign in_rom = (fetch_addr >= `EII_ROM_LO);

   // Fetch checks, one cycle after request
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         fetch_nonexist_r <= 1'b0;
         fetch_opcode_r   <= 8'h00;
         trap_reset_r     <= 1'b0;
      end
      else
      begin
         // missing memory reads as trap opcode
         fetch_nonexist_r <= fetch_valid & ~(in_ram | in_regs | in_dbuf | in_rom);
         fetch_opcode_r   <= `EII_TRAP_OP;
         trap_reset_r     <= fetch_valid & (in_ram | in_regs | in_dbuf);
      end
   end
endmodule

// ### core/eii_map.vh
/*
 * Constants for the external interrupt input block: register indices,
 * control fields, enable positions, filter counts and fetch ranges.
 * Assumes one clock of period 1/high_freq_clock feeding the block.
 */
`ifndef EII_MAP_VH
`define EII_MAP_VH
// Register indices; byte address is four times the index
`define EII_IDX_CTRL     8'h37
`define EII_IDX_LATCH    8'h38
`define EII_IDX_ENABLE   8'h39
`define EII_IDX_STATUS   8'h3a
// Control register fields
`define EII_CTRL_PINSEL  6
`define EII_CTRL_DES     4
`define EII_CTRL_BES     2
`define EII_CTRL_WMASK   8'h7d
`define EII_CTRL_RESET   8'h00
// Master and individual enable positions in the enable register
`define EII_EN_MASTER    0
`define EII_EN_A         3
`define EII_EN_B         7
`define EII_EN_C         11
`define EII_EN_D         12
`define EII_EN_E         15
// Filter limits in high_freq_clock periods
`define EII_AE_REJECT_CYC 2
`define EII_AE_ACCEPT_CYC 7
`define EII_BD_REJECT_CYC 7
`define EII_BD_ACCEPT_CYC 25
// Fetch map, 20-bit addresses
`define EII_RAM_LO       20'h00040
`define EII_RAM_HI       20'h0063f
`define EII_REGS_LO      20'h00000
`define EII_REGS_HI      20'h0003f
`define EII_DBUF_LO      20'h00f80
`define EII_DBUF_HI      20'h00fff
`define EII_ROM_LO       20'hf0000
`define EII_TRAP_OP      8'hff
`define EII_RESP_OK      2'b00
`define EII_RESP_ERR     2'b10
`endif

// ### core/eii_filter.v
/*
 * Digital noise filter for one synchronised interrupt pin.
 * Assumes the input already passed two flip-flops on clk.
 */
`timescale 1ns/100ps
module eii_filter
#(
   parameter COUNT = 2
)
(
   input  wire clk,
   input  wire rst_sync_b,
   input  wire level_in,
   output reg  level_r
);
   // Last count value before the output flips
   localparam integer LAST = COUNT - 1;

   reg [7:0] run_r;
   wire      differs;

   assign differs = (level_in != level_r);

   // Output follows only after COUNT steady differing samples
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         run_r   <= 8'h00;
         level_r <= 1'b1;
      end
      else if (!differs)
         run_r <= 8'h00;
      else if ({24'h000000, run_r} == LAST)
      begin
         run_r   <= 8'h00;
         level_r <= level_in;
      end
      else
         run_r <= run_r + 8'h01;
   end
endmodule

// ### sim/eii_pin_src.sv
/*
 * Pin source model: drives pins a, b, d, e of the block.
 * Assumes pull-ups, so each pin rests high when not pulled low.
 */
`timescale 1ns/100ps
module eii_pin_src
(
   input  wire       clk,
   output reg  [3:0] pin_r
);
   // Pull-ups hold every pin high at start
   initial pin_r = 4'hf;
   // Pin level changes just after a clock edge
   task set(input int i, input logic v);
      begin
         pin_r[i] <= v;
      end
   endtask
endmodule

// ### sim/eii_props.sv
/*
 * Port checker for eii_top: bus answers, fetch traps, pending bits.
 * Assumes a bind by matching port names from the bench top file.
 */
`timescale 1ns/100ps
`include "eii_map.vh"
module eii_props
(
   input wire        clk,
   input wire        rst_b,
   input wire        s_axi_awvalid,
   input wire        s_axi_wvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire        instr_last,
   input wire [4:0]  irq_ack,
   input wire [4:0]  irq_pending_r,
   input wire        fetch_valid,
   input wire [19:0] fetch_addr,
   input wire        fetch_nonexist_r,
   input wire [7:0]  fetch_opcode_r,
   input wire        trap_reset_r
);
   // Fetch into RAM, register or buffer area, or into a hole
   wire trap = fetch_addr <= `EII_RAM_HI ||
               (fetch_addr >= `EII_DBUF_LO && fetch_addr <= `EII_DBUF_HI);
   wire hole = !trap && fetch_addr < `EII_ROM_LO;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wr_answer_a:
      assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready &&
         s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
   bresp_hold_a:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
         $stable(s_axi_bresp)) else $error("write answer dropped");
   rd_answer_a:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   rdata_hold_a:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
         $stable(s_axi_rdata)) else $error("read answer dropped");
   trap_reset_a:
      assert property (fetch_valid |=> trap_reset_r == $past(trap))
      else $error("trap reset wrong");
   trap_opcode_a:
      assert property (fetch_valid && hole |=> fetch_nonexist_r &&
         fetch_opcode_r == `EII_TRAP_OP) else $error("hole fetch wrong");
   fetch_quiet_a:
      assert property (!fetch_valid |=> !trap_reset_r && !fetch_nonexist_r)
      else $error("fetch pulse without fetch");
   ack_clear_a:
      assert property (!instr_last && irq_ack != 5'h00 |=>
         (irq_pending_r & $past(irq_ack)) == 5'h00) else $error("ack kept");
   pend_hold_a:
      assert property (!instr_last && irq_ack == 5'h00 |=>
         $stable(irq_pending_r)) else $error("pending moved");
   cover property (fetch_valid && trap);
   cover property (s_axi_bvalid && s_axi_bresp == `EII_RESP_ERR);
   cover property (irq_pending_r == 5'h1f);
endmodule

// ### sim/test_eii_top.sv
/*
 * Self-checking bench for eii_top over AXI4-Lite, pins and CPU strobes.
 * Assumes eii_pin_src drives pins a, b, d, e and eii_props is bound.
 */
`timescale 1ns/100ps
`include "eii_map.vh"
module test_eii_top;
   reg         clk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   reg         s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   reg         remote_rx_input = 1, instr_last = 0, fetch_valid = 0;
   reg  [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, d;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg  [1:0]  remote_edge_sel = 0, r;
   reg  [4:0]  irq_ack = 0;
   reg  [19:0] fetch_addr = 0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire        s_axi_rvalid, port5_bit0_in_r, timer1_input_r;
   wire        fetch_nonexist_r, trap_reset_r;
   wire        ext_irq_a, ext_irq_b, ext_irq_d, ext_irq_e;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [4:0]  irq_pending_r;
   wire [7:0]  fetch_opcode_r;
   wire [3:0]  pin;
   integer     errors = 0, checks_done = 0, cyc = 0, k;
   reg  [19:0] fa [0:4];
   reg  [1:0]  fe [0:4];
   assign {ext_irq_e, ext_irq_d, ext_irq_b, ext_irq_a} = pin;
   eii_top dut (.*);
   eii_pin_src src (.clk(clk), .pin_r(pin));
   always #20 clk = ~clk;
   // Hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors = errors + 1;
         final_report;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            errors = errors + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] i, input [31:0] v, input [1:0] er);
      begin
         s_axi_awaddr <= {22'h0, i, 2'b00};
         s_axi_wdata <= v;
         s_axi_awvalid <= 1;
         s_axi_wvalid <= 1;
         s_axi_bready <= 1;
         @(posedge clk);
         while (!(s_axi_awready && s_axi_wready)) @(posedge clk);
         s_axi_awvalid <= 0;
         s_axi_wvalid <= 0;
         while (!s_axi_bvalid) @(posedge clk);
         chk(s_axi_bresp, er);
         s_axi_bready <= 0;
         @(posedge clk);
      end
   endtask
   task rd(input [7:0] i, output [31:0] v, output [1:0] rs);
      begin
         s_axi_araddr <= {22'h0, i, 2'b00};
         s_axi_arvalid <= 1;
         s_axi_rready <= 1;
         @(posedge clk);
         while (!s_axi_arready) @(posedge clk);
         s_axi_arvalid <= 0;
         while (!s_axi_rvalid) @(posedge clk);
         v = s_axi_rdata;
         rs = s_axi_rresp;
         s_axi_rready <= 0;
         @(posedge clk);
      end
   endtask
   // Hold pin low 30 cycles, read latches, release, read again
   task edg(input int i, input [31:0] ef, input [31:0] eb);
      begin
         wr(8'h38, 0, 2'b00);
         src.set(i, 1'b0);
         repeat (30) @(posedge clk);
         rd(8'h38, d, r);
         chk(d, ef);
         if (i == 1) chk(timer1_input_r, 0);
         src.set(i, 1'b1);
         repeat (30) @(posedge clk);
         rd(8'h38, d, r);
         chk(d, eb);
      end
   endtask
   // Low pulse of n cycles, then latch read
   task filt(input int i, input int n, input [31:0] e);
      begin
         wr(8'h38, 0, 2'b00);
         src.set(i, 1'b0);
         repeat (n) @(posedge clk);
         src.set(i, 1'b1);
         repeat (14) @(posedge clk);
         rd(8'h38, d, r);
         chk(d, e);
      end
   endtask
   task t_pins;
      begin
         src.set(0, 1'b0);
         repeat (4) @(posedge clk);
         chk(port5_bit0_in_r, 0);
         src.set(0, 1'b1);
         repeat (12) @(posedge clk);
         rd(8'h38, d, r);
         chk(d, 0);
         rd(8'h37, d, r);
         chk(d, 0);
         wr(8'h37, 32'h40, 2'b00);
         repeat (8) @(posedge clk);
         edg(0, 1, 1);
         chk(port5_bit0_in_r, 1);
         filt(0, 1, 0);
         filt(0, 7, 1);
         filt(3, 1, 0);
         filt(3, 7, 32'h10);
         filt(1, 6, 0);
         filt(1, 25, 2);
         edg(1, 0, 2);
         edg(2, 0, 8);
         wr(8'h37, 32'h54, 2'b00);
         repeat (8) @(posedge clk);
         edg(1, 2, 2);
         edg(2, 8, 8);
         src.set(1, 1'b0);
         repeat (20) @(posedge clk);
         wr(8'h38, 0, 2'b00);
         src.set(1, 1'b1);
         repeat (8) @(posedge clk);
         wr(8'h37, 32'h00, 2'b00);
         repeat (20) @(posedge clk);
         rd(8'h38, d, r);
         chk(d, 0);
         edg(0, 0, 0);
         for (k = 1; k < 4; k = k + 1)
         begin
            remote_edge_sel <= k[1:0];
            wr(8'h38, 0, 2'b00);
            remote_rx_input <= 0;
            repeat (3) @(posedge clk);
            rd(8'h38, d, r);
            chk(d, k[1] ? 4 : 0);
            remote_rx_input <= 1;
            repeat (3) @(posedge clk);
            rd(8'h38, d, r);
            chk(d, 4);
         end
         $display("pin test done");
      end
   endtask
   task t_enable;
      begin
         wr(8'h38, 32'h1f, 2'b00);
         wr(8'h39, 32'h9889, 2'b00);
         instr_last <= 1;
         @(posedge clk);
         instr_last <= 0;
         @(posedge clk);
         chk(irq_pending_r, 32'h1e);
         for (k = 0; k < 3; k = k + 1)
         begin
            wr(8'h39, 0, 2'b00);
            wr(8'h37, 32'h40, 2'b00);
            wr(8'h38, 32'h1f, 2'b00);
            wr(8'h39, k == 0 ? 32'h9888 : k == 1 ? 32'h0009 : 32'h9889, 2'b00);
            instr_last <= 1;
            @(posedge clk);
            instr_last <= 0;
            @(posedge clk);
            chk(irq_pending_r, k == 0 ? 0 : k == 1 ? 1 : 32'h1f);
         end
         irq_ack <= 5'h05;
         @(posedge clk);
         irq_ack <= 0;
         @(posedge clk);
         chk(irq_pending_r, 32'h1a);
         rd(8'h38, d, r);
         chk(d, 32'h1a);
         wr(8'h3a, 0, 2'b10);
         wr(8'h50, 0, 2'b10);
         rd(8'h50, d, r);
         chk(d, 32'h0);
         chk({30'h0, r}, 32'h2);
         rd(8'h3a, d, r);
         chk(d, 32'h1f);
         $display("enable test done");
      end
   endtask
   task t_fetch;
      begin
         fa[0] = 20'h00010; fa[1] = 20'h00100; fa[2] = 20'h00f90;
         fa[3] = 20'hf1000; fa[4] = 20'h10000;
         fe[0] = 1; fe[1] = 1; fe[2] = 1; fe[3] = 0; fe[4] = 2;
         for (k = 0; k < 5; k = k + 1)
         begin
            fetch_addr <= fa[k];
            fetch_valid <= 1;
            @(posedge clk);
            fetch_valid <= 0;
            @(posedge clk);
            chk({fetch_nonexist_r, trap_reset_r, fetch_opcode_r}, {fe[k], 8'hff});
         end
         $display("fetch test done");
      end
   endtask
   task final_report;
      begin
         $display("checks %0d errors %0d", checks_done, errors);
         if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
      t_pins;
      t_enable;
      t_fetch;
      final_report;
   end
endmodule
bind eii_top eii_props chk (.*);
